/* src/pio_input_allocator.sv */
/*
 * Input function allocator for two pulse I/O modules of ten terminals.
 * Routes each terminal to one function, filters normal inputs, latches
 * them into the input words at each I/O refresh and arms interrupt
 * feeding. Assumes an AXI4-Lite master on clk and field pins that are
 * asynchronous to clk.
 */
// How it works
// - Each terminal is handed to exactly one function and every other function sees it low.
// - Origin search outranks counter Z/reset, which outranks normal, interrupt and quick inputs.
// - Module 0 bit 3 is counter 0 Z/reset and bit 2 is counter 1 Z/reset.
// - Module 1 bit 3 is counter 2 Z/reset and bit 2 is counter 3 Z/reset.
// - Axis 0 takes origin from module 0 bit 0 and proximity from bit 1.
// - Axis 1 takes origin from module 0 bit 2 and proximity from bit 3.
// - Axis 2 takes origin from module 1 bit 0 and proximity from bit 1.
// - Axis 3 takes origin from module 1 bit 2 and proximity from bit 3.
// - Enabled interrupt feeding accepts only fixed interrupt and axis pairs and rejects others.
// - A normal input's filtered level is stored into its word bit at each I/O refresh.
// - The debounce filter is skipped on interrupt, quick and counter terminals.
`timescale 1ns/1ps
`include "pio_alloc_consts.svh"
module pio_input_allocator
    import pio_alloc_pkg::*;
#(
    parameter int AW             = 16,
    parameter int TICK_CYCLES    = `FILTER_STEP_CYC,
    parameter int REFRESH_CYCLES = `REFRESH_CYC
) (
    input  logic          clk,
    input  logic          rst,
    input  logic          ce,
    input  logic [19:0]   pinIn,
    input  logic [AW-1:0] awaddr,
    input  logic          awvalid,
    output logic          awready,
    input  logic [31:0]   wdata,
    input  logic [3:0]    wstrb,
    input  logic          wvalid,
    output logic          wready,
    output logic [1:0]    bresp,
    output logic          bvalid,
    input  logic          bready,
    input  logic [AW-1:0] araddr,
    input  logic          arvalid,
    output logic          arready,
    output logic [31:0]   rdata,
    output logic [1:0]    rresp,
    output logic          rvalid,
    input  logic          rready,
    output func_out_s     funcOut,
    output logic [3:0]    feedTrig
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam int RW = $clog2(REFRESH_CYCLES + 1);

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                awHave;
        logic                wHave;
        logic [AW-1:0]       wAddr;
        logic [31:0]         wData;
        logic [3:0]          wStrb;
        logic                arready;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        logic [1:0][15:0]    cfg;
        logic [3:0]          filtSel;
        feed_s               feed;
        logic                feedReject;
        logic [1:0][15:0]    word;
        func_out_s           fo;
        logic [3:0]          feedTrig;
        logic [TW-1:0]       tickCnt;
        logic                tick;
        logic [RW-1:0]       refCnt;
    } state_s;

    state_s s_q;
    state_s s_d;

    alloc_t [1:0]     owner;
    logic [1:0][9:0]  conflict;
    logic [19:0]      bypass;
    logic [19:0]      clean;
    logic [6:0]       limit;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Byte-lane merge of a write into a stored register value.
    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] data,
                                          logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = data[8*i +: 8];
        end
        return r;
    endfunction

    // Filter length in 0.5 ms steps; unused codes fall back to the default.
    function automatic logic [6:0] filterSteps(logic [3:0] sel);
        case (sel)
            4'h1:    return 7'h00;
            4'h2:    return 7'h01;
            4'h3:    return 7'h02;
            4'h4:    return 7'h04;
            4'h5:    return 7'h08;
            4'h6:    return 7'h10;
            4'h7:    return 7'h20;
            4'h8:    return 7'h40;
            default: return 7'h10;
        endcase
    endfunction

    // Each axis may be fed only from the interrupt at twice its index.
    function automatic logic feedPairOk(logic [2:0] intr, logic [1:0] axis);
        return intr == {axis, 1'b0};
    endfunction

    // ------------------------------------------------------------------
    // Allocation and input conditioning
    // ------------------------------------------------------------------

    // One resolver per module, so both modules obey the same priority.
    for (genvar m = 0; m < 2; m++) begin : g_mod
        function_resolver u_res (
            .cfg      (mod_cfg_s'(s_q.cfg[m])),
            .owner    (owner[m]),
            .conflict (conflict[m])
        );
        for (genvar b = 0; b < 10; b++) begin : g_byp
            // Fast functions must not see the filter delay.
            assign bypass[10*m + b] = (owner[m][b] == FN_INTR)  ||
                                      (owner[m][b] == FN_QUICK) ||
                                      (owner[m][b] == FN_CNT_Z) ||
                                      (owner[m][b] == FN_CNT_AB);
        end
    end

    assign limit = filterSteps(s_q.filtSel);

    input_conditioner #(
        .N  (20),
        .LW (7)
    ) u_cond (
        .clk    (clk),
        .rst    (rst),
        .ce     (ce),
        .pinIn  (pinIn),
        .bypass (bypass),
        .limit  (limit),
        .tick   (s_q.tick),
        .clean  (clean)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [31:0] v;
        logic [7:0]  rise;
        int          t;
        v        = 32'h0000_0000;
        rise     = 8'h00;
        t        = 0;
        s_d      = s_q;
        s_d.tick = 1'b0;

        // Filter step prescaler; one step every 0.5 ms.
        if (s_q.tickCnt >= TW'(TICK_CYCLES - 1)) begin
            s_d.tickCnt = '0;
            s_d.tick    = 1'b1;
        end else begin
            s_d.tickCnt = s_q.tickCnt + 1'b1;
        end

        // I/O refresh: only normal-input terminals land in the words.
        if (s_q.refCnt >= RW'(REFRESH_CYCLES - 1)) begin
            s_d.refCnt = '0;
            for (int m = 0; m < 2; m++) begin
                s_d.word[m] = 16'h0000;
                for (int b = 0; b < 10; b++) begin
                    s_d.word[m][b] = clean[10*m + b] &&
                                     (owner[m][b] == FN_NORMAL);
                end
            end
        end else begin
            s_d.refCnt = s_q.refCnt + 1'b1;
        end

        // Function outputs; a terminal reaches only its owner.
        s_d.fo = '0;
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 4; k++) begin
                t = 10*m + k;
                s_d.fo.intIn[4*m + k]   = clean[t] &&
                                          owner[m][k] == FN_INTR;
                s_d.fo.quickIn[4*m + k] = clean[t] &&
                                          owner[m][k] == FN_QUICK;
            end
            // Counter Z/reset: even counter on bit 3, odd on bit 2.
            s_d.fo.cntZ[2*m]     = clean[10*m + 3] &&
                                   owner[m][3] == FN_CNT_Z;
            s_d.fo.cntZ[2*m + 1] = clean[10*m + 2] &&
                                   owner[m][2] == FN_CNT_Z;
            // Phase inputs: odd counter on bits 6/7, even on bits 8/9.
            s_d.fo.cntA[2*m + 1] = clean[10*m + 6] &&
                                   owner[m][6] == FN_CNT_AB;
            s_d.fo.cntB[2*m + 1] = clean[10*m + 7] &&
                                   owner[m][7] == FN_CNT_AB;
            s_d.fo.cntA[2*m]     = clean[10*m + 8] &&
                                   owner[m][8] == FN_CNT_AB;
            s_d.fo.cntB[2*m]     = clean[10*m + 9] &&
                                   owner[m][9] == FN_CNT_AB;
            // Origin search: even axis on bits 0/1, odd axis on 2/3.
            for (int a = 0; a < 2; a++) begin
                s_d.fo.origin[2*m + a] = clean[10*m + 2*a] &&
                    owner[m][2*a] == FN_ORIGIN;
                s_d.fo.prox[2*m + a]   = clean[10*m + 2*a + 1] &&
                    owner[m][2*a + 1] == FN_ORIGIN;
                s_d.fo.posDone[2*m + a] = clean[10*m + 4 + a] &&
                    owner[m][4 + a] == FN_POS_DONE;
            end
        end

        // Feed trigger on a rising edge of the paired interrupt input.
        rise = s_d.fo.intIn & ~s_q.fo.intIn;
        for (int a = 0; a < 4; a++) begin
            s_d.feedTrig[a] = s_q.feed.en &&
                              s_q.feed.axis == 2'(a) &&
                              rise[s_q.feed.intrSel];
        end

        // Write address and data are taken independently.
        if (awvalid && s_q.awready) begin
            s_d.awready = 1'b0;
            s_d.awHave  = 1'b1;
            s_d.wAddr   = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.wready = 1'b0;
            s_d.wHave  = 1'b1;
            s_d.wData  = wdata;
            s_d.wStrb  = wstrb;
        end

        // Commit a write once both halves are held.
        if (s_q.awHave && s_q.wHave && !s_q.bvalid) begin
            s_d.awHave = 1'b0;
            s_d.wHave  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = `RESP_OKAY;
            case (s_q.wAddr)
                `ADDR_CFG0: begin
                    v          = merge({16'h0000, s_q.cfg[0]},
                                       s_q.wData, s_q.wStrb);
                    s_d.cfg[0] = v[15:0];
                end
                `ADDR_CFG1: begin
                    v          = merge({16'h0000, s_q.cfg[1]},
                                       s_q.wData, s_q.wStrb);
                    s_d.cfg[1] = v[15:0];
                end
                `ADDR_FILTER: begin
                    v           = merge({28'h000_0000, s_q.filtSel},
                                        s_q.wData, s_q.wStrb);
                    s_d.filtSel = v[3:0];
                end
                `ADDR_FEED: begin
                    v = merge(32'h0000_0000, s_q.wData, s_q.wStrb);
                    // Illegal pairs are refused and leave the feed as it was.
                    if (v[`FEED_EN_BIT] &&
                        !feedPairOk(v[`FEED_INTR_LSB +: 3],
                                    v[`FEED_AXIS_LSB +: 2])) begin
                        s_d.feedReject = 1'b1;
                    end else begin
                        s_d.feed.en      = v[`FEED_EN_BIT];
                        s_d.feed.axis    = v[`FEED_AXIS_LSB +: 2];
                        s_d.feed.intrSel = v[`FEED_INTR_LSB +: 3];
                        s_d.feedReject   = 1'b0;
                    end
                end
                `ADDR_MOD0_WORD, `ADDR_MOD1_WORD, `ADDR_ALLOC0,
                `ADDR_ALLOC1, `ADDR_STATUS: begin
                    s_d.bresp = `RESP_OKAY;
                end
                default: begin
                    s_d.bresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid  = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready  = 1'b1;
        end

        // Reads answer one cycle after the address is taken.
        if (arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rresp   = `RESP_OKAY;
            case (araddr)
                `ADDR_MOD0_WORD: s_d.rdata = {16'h0000, s_q.word[0]};
                `ADDR_MOD1_WORD: s_d.rdata = {16'h0000, s_q.word[1]};
                `ADDR_CFG0:      s_d.rdata = {16'h0000, s_q.cfg[0]};
                `ADDR_CFG1:      s_d.rdata = {16'h0000, s_q.cfg[1]};
                `ADDR_FILTER:    s_d.rdata = {28'h000_0000, s_q.filtSel};
                `ADDR_FEED: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rdata[`FEED_EN_BIT]          = s_q.feed.en;
                    s_d.rdata[`FEED_AXIS_LSB +: 2]   = s_q.feed.axis;
                    s_d.rdata[`FEED_INTR_LSB +: 3]   = s_q.feed.intrSel;
                end
                `ADDR_ALLOC0:    s_d.rdata = {2'b00, owner[0]};
                `ADDR_ALLOC1:    s_d.rdata = {2'b00, owner[1]};
                `ADDR_STATUS: begin
                    s_d.rdata = {22'h00_0000, conflict[0]};
                    s_d.rdata[`STAT_CONF1_LSB +: 10] = conflict[1];
                    s_d.rdata[`STAT_REJECT_BIT]      = s_q.feedReject;
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                    s_d.rresp = `RESP_SLVERR;
                end
            endcase
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // Everything, bus included, freezes while ce is low.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q         <= '0;
            s_q.awready <= 1'b1;
            s_q.wready  <= 1'b1;
            s_q.arready <= 1'b1;
            s_q.cfg     <= {`CFG_RESET, `CFG_RESET};
            s_q.filtSel <= `FILTER_RESET;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign awready  = s_q.awready;
    assign wready   = s_q.wready;
    assign bvalid   = s_q.bvalid;
    assign bresp    = s_q.bresp;
    assign arready  = s_q.arready;
    assign rvalid   = s_q.rvalid;
    assign rresp    = s_q.rresp;
    assign rdata    = s_q.rdata;
    assign funcOut  = s_q.fo;
    assign feedTrig = s_q.feedTrig;

endmodule

/* src/pio_alloc_consts.svh */
/*
 * Constants of the pulse I/O input function allocator: register byte
 * addresses, field positions, reset values and timing figures.
 * Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef PIO_ALLOC_CONSTS_SVH
`define PIO_ALLOC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses (byte address = index times four)
// ----------------------------------------------------------------------
`define IDX_MOD0_WORD    16'h0b90
`define IDX_MOD1_WORD    16'h0b92
`define ADDR_MOD0_WORD   (`IDX_MOD0_WORD << 2)
`define ADDR_MOD1_WORD   (`IDX_MOD1_WORD << 2)
`define ADDR_CFG0        16'h2e50
`define ADDR_CFG1        16'h2e54
`define ADDR_FILTER      16'h2e58
`define ADDR_FEED        16'h2e5c
`define ADDR_ALLOC0      16'h2e60
`define ADDR_ALLOC1      16'h2e64
`define ADDR_STATUS      16'h2e68

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FEED_INTR_LSB    0
`define FEED_AXIS_LSB    4
`define FEED_EN_BIT      8
`define STAT_CONF1_LSB   16
`define STAT_REJECT_BIT  26

// ----------------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------------
`define CFG_RESET        16'h0000
`define FILTER_RESET     4'h0
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS    10
`define FILTER_STEP_NS   500000
`define FILTER_STEP_CYC  (`FILTER_STEP_NS / `CLK_PERIOD_NS)
`define REFRESH_NS       1000000
`define REFRESH_CYC      (`REFRESH_NS / `CLK_PERIOD_NS)

`endif

/* src/pio_alloc_pkg.sv */
/*
 * Types shared by the input function allocator: terminal function codes,
 * per-module configuration, feed pairing and the function output bundle.
 * Assumes two modules of ten input terminals each.
 */
package pio_alloc_pkg;

    // Function that currently owns one input terminal.
    typedef enum logic [2:0] {
        FN_NORMAL   = 3'h0,
        FN_INTR     = 3'h1,
        FN_QUICK    = 3'h2,
        FN_CNT_Z    = 3'h3,
        FN_CNT_AB   = 3'h4,
        FN_ORIGIN   = 3'h5,
        FN_POS_DONE = 3'h6
    } func_e;

    typedef func_e [9:0] alloc_t;

    // Per-module selection; index 0 is the even counter or axis.
    typedef struct packed {
        logic [1:0] posDoneEn;
        logic [1:0] originEn;
        logic [1:0] cntAbEn;
        logic [1:0] cntZEn;
        logic [3:0] quickEn;
        logic [3:0] intrEn;
    } mod_cfg_s;

    typedef struct packed {
        logic       en;
        logic [1:0] axis;
        logic [2:0] intrSel;
    } feed_s;

    typedef struct packed {
        logic [7:0] intIn;
        logic [7:0] quickIn;
        logic [3:0] cntA;
        logic [3:0] cntB;
        logic [3:0] cntZ;
        logic [3:0] origin;
        logic [3:0] prox;
        logic [3:0] posDone;
    } func_out_s;

endpackage

/* src/function_resolver.sv */
/*
 * Priority resolver for the ten terminals of one module.
 * Assumes the configuration comes from registers on the same clock.
 */
`timescale 1ns/1ps
module function_resolver
    import pio_alloc_pkg::*;
(
    input  mod_cfg_s   cfg,
    output alloc_t     owner,
    output logic [9:0] conflict
);

    // Requests on terminal b: {posDone, origin, cntZ, cntAB, intr, quick}.
    function automatic logic [5:0] requests(mod_cfg_s c, int b);
        logic [5:0] r;
        r = 6'h00;
        if (b < 4) begin
            r[1] = c.intrEn[b];
            r[0] = c.quickEn[b];
            r[4] = c.originEn[b / 2];
        end
        if (b == 2) r[3] = c.cntZEn[1];
        if (b == 3) r[3] = c.cntZEn[0];
        if (b == 4 || b == 5) r[5] = c.posDoneEn[b - 4];
        if (b == 6 || b == 7) r[2] = c.cntAbEn[1];
        if (b == 8 || b == 9) r[2] = c.cntAbEn[0];
        return r;
    endfunction

    // Origin search beats position done, which beats counter Z/reset, which beats the rest.
    function automatic func_e pick(logic [5:0] r);
        if (r[4])      return FN_ORIGIN;
        else if (r[5]) return FN_POS_DONE;
        else if (r[3]) return FN_CNT_Z;
        else if (r[2]) return FN_CNT_AB;
        else if (r[1]) return FN_INTR;
        else if (r[0]) return FN_QUICK;
        else           return FN_NORMAL;
    endfunction

    // One owner per terminal; overlapping requests are flagged.
    for (genvar b = 0; b < 10; b++) begin : g_term
        assign owner[b]    = pick(requests(cfg, b));
        assign conflict[b] = ($countones(requests(cfg, b)) > 1);
    end

endmodule

/* src/input_conditioner.sv */
/*
 * Pin synchroniser and debounce filter for the input terminals.
 * Assumes a filter step tick from the same clock domain.
 */
`timescale 1ns/1ps
module input_conditioner #(
    parameter int N  = 20,
    parameter int LW = 7
) (
    input  logic          clk,
    input  logic          rst,
    input  logic          ce,
    input  logic [N-1:0]  pinIn,
    input  logic [N-1:0]  bypass,
    input  logic [LW-1:0] limit,
    input  logic          tick,
    output logic [N-1:0]  clean
);

    typedef struct packed {
        logic [N-1:0]         sync1;
        logic [N-1:0]         sync2;
        logic [N-1:0]         clean;
        logic [N-1:0][LW-1:0] cnt;
    } state_s;

    state_s s_q;
    state_s s_d;

    // A level change is accepted once it has held for limit filter steps.
    always_comb begin
        s_d       = s_q;
        s_d.sync1 = pinIn;
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < N; i++) begin
            if (bypass[i] || limit == '0) begin
                s_d.clean[i] = s_q.sync2[i];
                s_d.cnt[i]   = '0;
            end else if (s_q.sync2[i] == s_q.clean[i]) begin
                s_d.cnt[i] = '0;
            end else if (tick) begin
                if (s_q.cnt[i] + 1'b1 >= limit) begin
                    s_d.clean[i] = s_q.sync2[i];
                    s_d.cnt[i]   = '0;
                end else begin
                    s_d.cnt[i] = s_q.cnt[i] + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign clean = s_q.clean;

endmodule

/* dv/pio_alloc_monitor.sv */
/* Checker on the allocator's function outputs.
 * Assumes ce high and the input filter switched off. */
`timescale 1ns/1ps
module pio_alloc_monitor
    import pio_alloc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [19:0] pinIn,
    input wire func_out_s   funcOut,
    input wire logic [3:0]  feedTrig
);
    // Unfiltered paths take four edges, so a high output needs an old pin.
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_EXCL: assert property (!(|(funcOut.intIn & funcOut.quickIn)))
        else $error("terminal given to two functions");
    AST_PRIO: assert property (!(funcOut.origin[1] && funcOut.cntZ[1]))
        else $error("origin and counter share a terminal");
    AST_Z0: assert property (funcOut.cntZ[0] |-> $past(pinIn[3], 4))
        else $error("counter 0 reset from wrong terminal");
    AST_Z2: assert property (funcOut.cntZ[2] |-> $past(pinIn[13], 4))
        else $error("counter 2 reset from wrong terminal");
    AST_QK: assert property (funcOut.quickIn[4] |-> $past(pinIn[10], 4))
        else $error("quick input 4 from wrong terminal");
    AST_AB: assert property (funcOut.cntA[1] |-> $past(pinIn[6], 4))
        else $error("counter 1 phase A from wrong terminal");
    AST_BYP: assert property (funcOut.intIn[0] |-> $past(pinIn[0], 4))
        else $error("interrupt input delayed by filter");
    AST_FEED: assert property (feedTrig[1] |-> funcOut.intIn[2])
        else $error("axis 1 feed without interrupt 2");
endmodule
bind pio_input_allocator pio_alloc_monitor pio_alloc_monitor_i (
    .clk(clk), .rst(rst), .pinIn(pinIn), .funcOut(funcOut),
    .feedTrig(feedTrig));

/* dv/field_sensors.sv */
/* Field sensors and encoders on the twenty terminals.
 * Assumes the bench sets levels just after a clock edge. */
`timescale 1ns/1ps
module field_sensors (
    input  wire logic        clk,
    input  wire logic [19:0] level,
    output logic      [19:0] pinIn
);
    // Contacts settle one edge after the bench moves them.
    always_ff @(posedge clk) begin
        pinIn <= level;
    end
endmodule

/* dv/tb.sv */
/* Bench of the input allocator with a reference model.
 * Assumes short tick and refresh counts. */
`timescale 1ns/1ps
`include "pio_alloc_consts.svh"
module tb
    import pio_alloc_pkg::*;
;
    logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
    logic [15:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rdv, w[2], seed = 28979;
    logic [19:0] level = 0, pinIn;
    logic [1:0] bresp, rresp, rsp;
    logic rvalid, v;
    logic [3:0] feedTrig;
    mod_cfg_s c[2];
    func_out_s funcOut, fo;
    int failures = 0, comparisons = 0, o, k;
    field_sensors field_sensors_i (.clk, .level, .pinIn);
    pio_input_allocator #(.TICK_CYCLES(4), .REFRESH_CYCLES(8))
        pio_input_allocator_i (.clk, .rst, .ce(1'b1), .pinIn, .awaddr,
        .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .funcOut, .feedTrig);
    initial forever #5 clk = ~clk;
    // The watchdog stops a hung bus wait.
    initial begin
        #200us;
        failures++;
        end_sim();
    end
    // ------------------------------------------------------------------
    // Model and bus tasks
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int own(mod_cfg_s m, int b);
        if (b < 4 && m.originEn[b/2]) return 5;
        if (b inside {4, 5} && m.posDoneEn[b-4]) return 6;
        if (b inside {2, 3} && m.cntZEn[3-b]) return 3;
        if (b > 5 && m.cntAbEn[b < 8]) return 4;
        if (b < 4 && m.intrEn[b]) return 1;
        if (b < 4 && m.quickEn[b]) return 2;
        return 0;
    endfunction
    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Each channel drops its valid at the edge where it was taken.
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        bready <= 0;
        rsp = bresp;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rready <= 0;
        rdv = rdata;
        rsp = rresp;
    endtask
    task automatic end_sim();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Random configurations deliberately overlap to exercise priority.
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        rd(16'h2e70);
        chk({rsp, rdv}, {`RESP_SLVERR, 32'h0});
        wr(16'h2e70, 32'h0);
        chk(rsp, `RESP_SLVERR);
        wr(`ADDR_FILTER, 32'h1);
        repeat (8) begin
            c[0] = 16'(rnd());
            c[1] = 16'(rnd());
            wr(`ADDR_CFG0, 32'(c[0]));
            wr(`ADDR_CFG1, 32'(c[1]));
            level <= 20'(rnd());
            repeat (24) @(posedge clk);
            fo = '0;
            w = '{0, 0};
            for (int i = 0; i < 20; i++) begin
                k = i / 10;
                o = own(c[k], i % 10);
                v = level[i];
                case (o)
                    0: w[k][i%10] = v;
                    1: fo.intIn[4*k+i%10] = v;
                    2: fo.quickIn[4*k+i%10] = v;
                    3: fo.cntZ[2*k+3-i%10] = v;
                    4: if (i % 2 == 0) fo.cntA[2*k+(i%10<8)] = v;
                       else fo.cntB[2*k+(i%10<8)] = v;
                    5: if (i % 2 == 0) fo.origin[2*k+i%10/2] = v;
                       else fo.prox[2*k+i%10/2] = v;
                    default: fo.posDone[2*k+i%10-4] = v;
                endcase
            end
            chk(funcOut, fo);
            rd(`ADDR_MOD0_WORD);
            chk(rdv, w[0]);
            rd(`ADDR_MOD1_WORD);
            chk(rdv, w[1]);
            rd(`ADDR_ALLOC0);
            for (int i = 0; i < 10; i++)
                chk(rdv[3*i+:3], own(c[0], i));
        end
        wr(`ADDR_FEED, 32'h0000_0101);
        chk(rsp, `RESP_OKAY);
        rd(`ADDR_STATUS);
        chk(rdv[26], 1'b1);
        wr(`ADDR_FEED, 32'h0000_0112);
        rd(`ADDR_STATUS);
        chk(rdv[26], 1'b0);
        // One function per terminal from here on.
        wr(`ADDR_CFG0, 32'h4);
        wr(`ADDR_CFG1, 32'h0);
        rd(`ADDR_STATUS);
        chk(rdv[25:0], 26'h0);
        level <= 0;
        repeat (8) @(posedge clk);
        level <= 20'h4;
        o = 0;
        k = 0;
        repeat (8) begin
            @(posedge clk);
            o += feedTrig[1];
            k |= feedTrig;
        end
        chk(o, 1);
        chk(k, 2);
        end_sim();
    end
endmodule
